// ==== rtl/tmo_pkg.sv ====
// package: register map, field layout, timing and state types of the output/request control
package tmo_pkg;

    // ------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam logic [ADDR_W-1:0] OFF_OUT_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_REQ_EN = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_SW_GEN = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_CH_PEND = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_CH_ACT = 8'h1c;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_NEG_IDLE = 9;
    localparam int unsigned BIT_MAIN_IDLE = 8;
    localparam int unsigned BIT_DMA_SEL = 3;
    localparam int unsigned BIT_UPD_SEL = 2;
    localparam int unsigned BIT_PRE_EN = 0;
    localparam int unsigned BIT_CH1_DE = 9;
    localparam int unsigned BIT_UPD_DE = 8;
    localparam int unsigned BIT_BRK_IE = 7;
    localparam int unsigned BIT_SW_IE = 5;
    localparam int unsigned BIT_CH1_IE = 1;
    localparam int unsigned BIT_UPD_IE = 0;
    localparam int unsigned BIT_SW_GEN = 5;
    localparam int unsigned BIT_CH_OE = 0;
    localparam int unsigned BIT_CH_NE = 2;
    localparam int unsigned MODE_LSB = 4;
    localparam int unsigned MODE_W = 3;

    // sticky flags: index in the flag array
    localparam int unsigned N_FLAGS = 4;
    localparam int unsigned IDX_UPD = 0;
    localparam int unsigned IDX_CC1 = 1;
    localparam int unsigned IDX_SW = 2;
    localparam int unsigned IDX_BRK = 3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned DEAD_TIME_NS = 100;
    localparam int unsigned DT_CNT_W = 8;
    localparam logic [DT_CNT_W-1:0] DEAD_CYCLES_DFLT =
        DT_CNT_W'((DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // state types and reset values
    // ------------------------------------------------------------
    typedef struct packed {
        logic neg_idle;
        logic main_idle;
        logic dma_sel;
        logic upd_sel;
        logic pre_en;
        logic ch1_de;
        logic upd_de;
        logic brk_ie;
        logic sw_ie;
        logic ch1_ie;
        logic upd_ie;
        logic pend_oe;
        logic pend_ne;
        logic [MODE_W-1:0] pend_mode;
        logic act_oe;
        logic act_ne;
        logic [MODE_W-1:0] act_mode;
        logic trig_d;
        logic [DT_CNT_W-1:0] dt_cnt;
        logic out_main;
        logic out_neg;
        logic dma_ch1;
        logic dma_upd;
        logic irq;
        logic [DATA_W-1:0] rdata;
    } tmo_state_s;

    typedef struct packed {
        logic q;
    } tmo_flag_s;

    localparam tmo_state_s TMO_STATE_RST = '0;
    localparam tmo_flag_s TMO_FLAG_RST = '0;
endpackage

// ==== rtl/tmo_flag_if.sv ====
// interface: set, clear and value of one sticky event flag
`timescale 1ns/10ps
`default_nettype none
interface tmo_flag_if;
    logic set;
    logic clr;
    logic q;
    modport owner (output set, output clr, input q);
    modport flag (input set, input clr, output q);
endinterface
`default_nettype wire

// ==== rtl/tmo_sticky_flag.sv ====
// module: one sticky event flag, set by hardware, cleared by writing one
`timescale 1ns/10ps
`default_nettype none
module tmo_sticky_flag
    import tmo_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // flag handshake
    tmo_flag_if.flag fl
);
    tmo_flag_s st;
    tmo_flag_s next_st;

    // set beats clear so an event in the clearing cycle survives
    always_comb begin
        next_st = st;
        if (fl.set) begin
            next_st.q = 1'b1;
        end else if (fl.clr) begin
            next_st.q = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= TMO_FLAG_RST;
        end else begin
            st <= next_st;
        end
    end

    assign fl.q = st.q;

    property p_set_wins;
        @(posedge clk) disable iff (!arst_n) fl.set |=> fl.q;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag lost its set");
endmodule
`default_nettype wire

// ==== rtl/tmo_ctrl.sv ====
// module: idle levels, preload transfer and interrupt/dma request enables of a timer channel
`timescale 1ns/10ps
`default_nettype none
module tmo_ctrl
    import tmo_pkg::*;
#(
    parameter logic HAS_NEG = 1'b1,
    parameter logic [DT_CNT_W-1:0] DEAD_CYCLES = DEAD_CYCLES_DFLT
)
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    // register port
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DATA_W-1:0] RDATA,
    // timer kernel events and levels
    input wire logic UPD_EVT,
    input wire logic CC1_EVT,
    input wire logic BRK_EVT,
    input wire logic TRIGGER_INPUT,
    input wire logic MAIN_OUTPUT_ENABLE,
    input wire logic [1:0] LOCK_LEVEL,
    input wire logic RUN_MAIN,
    input wire logic RUN_NEG,
    // channel outputs
    output logic CHAN1_MAIN_OUTPUT,
    output logic CHAN1_NEGATED_OUTPUT,
    output logic [MODE_W-1:0] CHAN_OUTPUT_BEHAVIOUR,
    // requests
    output logic CHAN1_DMA_REQ,
    output logic UPD_DMA_REQ,
    output logic IRQ
);
    tmo_state_s st;
    tmo_state_s next_st;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic wr_ctrl;
    logic wr_en;
    logic wr_stat;
    logic wr_gen;
    logic wr_ch;
    logic sw_switch;
    logic trig_rise;
    logic pre_en_eff;
    logic upd_sel_eff;
    logic switch_evt;
    logic dt_done;
    logic [N_FLAGS-1:0] flag_set;
    logic [N_FLAGS-1:0] flag_clr;
    logic [N_FLAGS-1:0] flag_q;
    logic [N_FLAGS-1:0] flag_en;

    // register strobes per address
    assign wr_ctrl = WR && (ADDR == OFF_OUT_CTRL);
    assign wr_en = WR && (ADDR == OFF_REQ_EN);
    assign wr_stat = WR && (ADDR == OFF_STATUS);
    assign wr_gen = WR && (ADDR == OFF_SW_GEN);
    assign wr_ch = WR && (ADDR == OFF_CH_PEND);
    assign sw_switch = wr_gen && WDATA[BIT_SW_GEN];

    // a channel with no complementary output sees preload and select as zero
    assign pre_en_eff = HAS_NEG && st.pre_en;
    assign upd_sel_eff = HAS_NEG && st.upd_sel;

    // trigger is taken as synchronous; one flop of history gives the edge
    assign trig_rise = TRIGGER_INPUT && !st.trig_d;
    assign switch_evt = sw_switch || (pre_en_eff && upd_sel_eff && trig_rise);
    assign dt_done = (st.dt_cnt == DEAD_CYCLES);

    // ------------------------------------------------------------
    // sticky flags
    // ------------------------------------------------------------
    // event sources of each flag
    assign flag_set[IDX_UPD] = UPD_EVT;
    assign flag_set[IDX_CC1] = CC1_EVT;
    assign flag_set[IDX_SW] = switch_evt;
    assign flag_set[IDX_BRK] = BRK_EVT;

    // write one to clear, at the flag's own enable position
    assign flag_clr[IDX_UPD] = wr_stat && WDATA[BIT_UPD_IE];
    assign flag_clr[IDX_CC1] = wr_stat && WDATA[BIT_CH1_IE];
    assign flag_clr[IDX_SW] = wr_stat && WDATA[BIT_SW_IE];
    assign flag_clr[IDX_BRK] = wr_stat && WDATA[BIT_BRK_IE];

    // enable of each flag onto the interrupt line
    assign flag_en[IDX_UPD] = st.upd_ie;
    assign flag_en[IDX_CC1] = st.ch1_ie;
    assign flag_en[IDX_SW] = st.sw_ie;
    assign flag_en[IDX_BRK] = st.brk_ie;

    tmo_flag_if fif[N_FLAGS] ();

    genvar gi;
    generate
        for (gi = 0; gi < N_FLAGS; gi++) begin : g_flag
            assign fif[gi].set = flag_set[gi];
            assign fif[gi].clr = flag_clr[gi];
            assign flag_q[gi] = fif[gi].q;
            tmo_sticky_flag u_flag (
                .clk(CLK_SYS),
                .arst_n(ARST_N),
                .fl(fif[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // registers, preload transfer, dead time, requests and read data
    always_comb begin
        next_st = st;
        next_st.trig_d = TRIGGER_INPUT;

        // control register; idle levels frozen once locked
        if (wr_ctrl) begin
            if (LOCK_LEVEL == 2'b00) begin
                next_st.neg_idle = WDATA[BIT_NEG_IDLE];
                next_st.main_idle = WDATA[BIT_MAIN_IDLE];
            end
            next_st.dma_sel = WDATA[BIT_DMA_SEL];
            next_st.upd_sel = WDATA[BIT_UPD_SEL];
            next_st.pre_en = WDATA[BIT_PRE_EN];
        end

        // request enable register
        if (wr_en) begin
            next_st.ch1_de = WDATA[BIT_CH1_DE];
            next_st.upd_de = WDATA[BIT_UPD_DE];
            next_st.brk_ie = WDATA[BIT_BRK_IE];
            next_st.sw_ie = WDATA[BIT_SW_IE];
            next_st.ch1_ie = WDATA[BIT_CH1_IE];
            next_st.upd_ie = WDATA[BIT_UPD_IE];
        end

        // channel control: direct without preload, buffered with it
        if (wr_ch) begin
            next_st.pend_oe = WDATA[BIT_CH_OE];
            next_st.pend_ne = WDATA[BIT_CH_NE];
            next_st.pend_mode = WDATA[MODE_LSB +: MODE_W];
            if (!pre_en_eff) begin
                next_st.act_oe = WDATA[BIT_CH_OE];
                next_st.act_ne = WDATA[BIT_CH_NE];
                next_st.act_mode = WDATA[MODE_LSB +: MODE_W];
            end
        end
        if (pre_en_eff && switch_evt) begin
            next_st.act_oe = st.pend_oe;
            next_st.act_ne = st.pend_ne;
            next_st.act_mode = st.pend_mode;
        end

        // dead time restarts each time the main enable drops
        if (MAIN_OUTPUT_ENABLE) begin
            next_st.dt_cnt = '0;
        end else if (!dt_done) begin
            next_st.dt_cnt = st.dt_cnt + 1'b1;
        end

        // outputs stay low through dead time, then take idle levels when HAS_NEG is set, else stay low
        if (MAIN_OUTPUT_ENABLE) begin
            next_st.out_main = st.act_oe && RUN_MAIN;
            next_st.out_neg = HAS_NEG && st.act_ne && RUN_NEG;
        end else if (dt_done) begin
            next_st.out_main = HAS_NEG && st.main_idle;
            next_st.out_neg = HAS_NEG && st.neg_idle;
        end else begin
            next_st.out_main = 1'b0;
            next_st.out_neg = 1'b0;
        end

        // dma requests, one cycle per event
        next_st.dma_ch1 = st.ch1_de && (st.dma_sel ? UPD_EVT : CC1_EVT);
        next_st.dma_upd = st.upd_de && UPD_EVT;
        next_st.irq = |(flag_q & flag_en);

        // read data stands only in the cycle after the strobe
        next_st.rdata = '0;
        if (RD) begin
            case (ADDR)
                OFF_OUT_CTRL: begin
                    next_st.rdata[BIT_NEG_IDLE] = st.neg_idle;
                    next_st.rdata[BIT_MAIN_IDLE] = st.main_idle;
                    next_st.rdata[BIT_DMA_SEL] = st.dma_sel;
                    next_st.rdata[BIT_UPD_SEL] = st.upd_sel;
                    next_st.rdata[BIT_PRE_EN] = st.pre_en;
                end
                OFF_REQ_EN: begin
                    next_st.rdata[BIT_CH1_DE] = st.ch1_de;
                    next_st.rdata[BIT_UPD_DE] = st.upd_de;
                    next_st.rdata[BIT_BRK_IE] = st.brk_ie;
                    next_st.rdata[BIT_SW_IE] = st.sw_ie;
                    next_st.rdata[BIT_CH1_IE] = st.ch1_ie;
                    next_st.rdata[BIT_UPD_IE] = st.upd_ie;
                end
                OFF_STATUS: begin
                    next_st.rdata[BIT_UPD_IE] = flag_q[IDX_UPD];
                    next_st.rdata[BIT_CH1_IE] = flag_q[IDX_CC1];
                    next_st.rdata[BIT_SW_IE] = flag_q[IDX_SW];
                    next_st.rdata[BIT_BRK_IE] = flag_q[IDX_BRK];
                end
                OFF_CH_PEND: begin
                    next_st.rdata[BIT_CH_OE] = st.pend_oe;
                    next_st.rdata[BIT_CH_NE] = st.pend_ne;
                    next_st.rdata[MODE_LSB +: MODE_W] = st.pend_mode;
                end
                OFF_CH_ACT: begin
                    next_st.rdata[BIT_CH_OE] = st.act_oe;
                    next_st.rdata[BIT_CH_NE] = st.act_ne;
                    next_st.rdata[MODE_LSB +: MODE_W] = st.act_mode;
                end
                default: begin
                    next_st.rdata = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // one register for the whole block state except the sticky flags
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            st <= TMO_STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign RDATA = st.rdata;
    assign CHAN1_MAIN_OUTPUT = st.out_main;
    assign CHAN1_NEGATED_OUTPUT = st.out_neg;
    assign CHAN_OUTPUT_BEHAVIOUR = st.act_mode;
    assign CHAN1_DMA_REQ = st.dma_ch1;
    assign UPD_DMA_REQ = st.dma_upd;
    assign IRQ = st.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);

    sequence s_idle_settled;
        !MAIN_OUTPUT_ENABLE && dt_done;
    endsequence

    sequence s_enable_drop;
        MAIN_OUTPUT_ENABLE ##1 !MAIN_OUTPUT_ENABLE;
    endsequence

    property p_neg_idle;
        s_idle_settled |=> (CHAN1_NEGATED_OUTPUT == (HAS_NEG && $past(st.neg_idle)));
    endproperty
    a_neg_idle: assert property (p_neg_idle) else $error("negated idle level wrong");

    property p_main_idle;
        s_idle_settled |=> (CHAN1_MAIN_OUTPUT == (HAS_NEG && $past(st.main_idle)));
    endproperty
    a_main_idle: assert property (p_main_idle) else $error("main idle level wrong");

    property p_dead_low;
        s_enable_drop ##0 (DEAD_CYCLES > 1) |=> !CHAN1_MAIN_OUTPUT && !CHAN1_NEGATED_OUTPUT;
    endproperty
    a_dead_low: assert property (p_dead_low) else $error("output not low in dead time");

    property p_idle_lock;
        (LOCK_LEVEL != 2'b00) |=> $stable(st.neg_idle) && $stable(st.main_idle);
    endproperty
    a_idle_lock: assert property (p_idle_lock) else $error("locked idle bit changed");

    property p_ch1_dma;
        st.ch1_de && (st.dma_sel ? UPD_EVT : CC1_EVT) |=> CHAN1_DMA_REQ;
    endproperty
    a_ch1_dma: assert property (p_ch1_dma) else $error("channel dma request missing");

    property p_ch1_dma_off;
        !st.ch1_de |=> !CHAN1_DMA_REQ;
    endproperty
    a_ch1_dma_off: assert property (p_ch1_dma_off) else $error("disabled dma request");

    property p_upd_dma_off;
        !st.upd_de || !UPD_EVT |=> !UPD_DMA_REQ;
    endproperty
    a_upd_dma_off: assert property (p_upd_dma_off) else $error("update dma unexpected");

    property p_hold_no_switch;
        pre_en_eff && !switch_evt |=> (st.act_mode == $past(st.act_mode)) && $stable(st.act_oe);
    endproperty
    a_hold_no_switch: assert property (p_hold_no_switch) else $error("preload leaked");

    property p_trig_xfer;
        pre_en_eff && upd_sel_eff && trig_rise |=> (st.act_mode == $past(st.pend_mode));
    endproperty
    a_trig_xfer: assert property (p_trig_xfer) else $error("trigger did not transfer");

    property p_irq;
        (flag_q[IDX_BRK] && st.brk_ie) || (flag_q[IDX_SW] && st.sw_ie) |=> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_irq_masked;
        (flag_q & flag_en) == '0 |=> !IRQ;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt seen");

    // an update event must not leak through while the match is the selected source
    property p_ch1_dma_src;
        st.ch1_de && !st.dma_sel && !CC1_EVT |=> !CHAN1_DMA_REQ;
    endproperty
    a_ch1_dma_src: assert property (p_ch1_dma_src) else $error("dma from wrong source");

    property p_sw_flag;
        switch_evt |=> flag_q[IDX_SW];
    endproperty
    a_sw_flag: assert property (p_sw_flag) else $error("switch flag not set");

    property p_direct_write;
        wr_ch && !pre_en_eff |=> (st.act_mode == $past(WDATA[MODE_LSB +: MODE_W]));
    endproperty
    a_direct_write: assert property (p_direct_write) else $error("direct write lost");

    property p_sw_xfer;
        pre_en_eff && sw_switch |=> (st.act_mode == $past(st.pend_mode))
            && (st.act_ne == $past(st.pend_ne));
    endproperty
    a_sw_xfer: assert property (p_sw_xfer) else $error("software switch lost");

    property p_rsvd_zero;
        RD && (ADDR == OFF_OUT_CTRL) |=> ((RDATA & 16'hfcf2) == 16'h0000);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one");

    property p_upd_irq;
        flag_q[IDX_UPD] && st.upd_ie |=> IRQ;
    endproperty
    a_upd_irq: assert property (p_upd_irq) else $error("update interrupt missing");
endmodule
`default_nettype wire

// ==== bench/tmo_req_sink.sv ====
// partner model: dma controller side that counts request pulses from the timer
`timescale 1ns/10ps
`default_nettype none
module tmo_req_sink (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // requests from the timer
    input wire logic ch1_dma_req,
    input wire logic upd_dma_req,
    // accepted transfers
    output var int n_ch1,
    output var int n_upd
);
    // one transfer per request cycle, so a stuck request shows as extra counts
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            n_ch1 <= 0;
            n_upd <= 0;
        end else begin
            if (ch1_dma_req) begin
                n_ch1 <= n_ch1 + 1;
            end
            if (upd_dma_req) begin
                n_upd <= n_upd + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// testbench: registers, requests, preload transfer and idle levels of the output control
`timescale 1ns/10ps
`default_nettype none
module tb;
    import tmo_pkg::*;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic clk_sys, arst_n, wr, rd, trig, main_en, run_m, run_n;
    logic out_m, out_n, ch1_req, upd_req, irq;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [MODE_W-1:0] mode;
    logic [2:0] evt;
    logic [1:0] lock;
    int n_ch1, n_upd, failures, n_checks;

    // short dead time keeps the idle scenario brief
    tmo_ctrl #(.HAS_NEG(1'b1), .DEAD_CYCLES(8'h04)) u_dut (
        .CLK_SYS(clk_sys), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .UPD_EVT(evt[0]), .CC1_EVT(evt[1]),
        .BRK_EVT(evt[2]), .TRIGGER_INPUT(trig), .MAIN_OUTPUT_ENABLE(main_en),
        .LOCK_LEVEL(lock), .RUN_MAIN(run_m), .RUN_NEG(run_n),
        .CHAN1_MAIN_OUTPUT(out_m), .CHAN1_NEGATED_OUTPUT(out_n),
        .CHAN_OUTPUT_BEHAVIOUR(mode), .CHAN1_DMA_REQ(ch1_req),
        .UPD_DMA_REQ(upd_req), .IRQ(irq));

    tmo_req_sink u_sink (.clk(clk_sys), .arst_n(arst_n), .ch1_dma_req(ch1_req),
        .upd_dma_req(upd_req), .n_ch1(n_ch1), .n_upd(n_upd));

    // 250 mhz clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // bus, event and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // wait n edges, then step off the edge so outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic pulse(input logic [2:0] m);
        @(posedge clk_sys);
        evt <= m;
        @(posedge clk_sys);
        evt <= 3'h0;
    endtask

    task automatic trig_rise();
        @(posedge clk_sys);
        trig <= 1'b1;
        cyc(2);
        @(posedge clk_sys);
        trig <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd_chk(OFF_OUT_CTRL, 16'h0000);
        rd_chk(OFF_REQ_EN, 16'h0000);
        wr_reg(OFF_OUT_CTRL, 16'hffff);
        rd_chk(OFF_OUT_CTRL, 16'h030d);
        wr_reg(OFF_REQ_EN, 16'hffff);
        rd_chk(OFF_REQ_EN, 16'h03a3);
        rd_chk(8'h20, 16'h0000);
        rd_chk(OFF_SW_GEN, 16'h0000);
        wr_reg(OFF_REQ_EN, 16'h0000);
        wr_reg(OFF_OUT_CTRL, 16'h0000);
    endtask

    // every nonzero lock level freezes the idle bits, others stay writable
    task automatic t_lock();
        wr_reg(OFF_OUT_CTRL, 16'h030c);
        for (int l = 1; l < 4; l++) begin
            @(posedge clk_sys);
            lock <= 2'(l);
            wr_reg(OFF_OUT_CTRL, 16'h0000);
            rd_chk(OFF_OUT_CTRL, 16'h0300);
            wr_reg(OFF_OUT_CTRL, 16'h030c);
        end
        @(posedge clk_sys);
        lock <= 2'h0;
        wr_reg(OFF_OUT_CTRL, 16'h0000);
        rd_chk(OFF_OUT_CTRL, 16'h0000);
    endtask

    // source select and enables for both dma requests
    task automatic t_dma();
        int c0, u0;
        logic s, en;
        for (int k = 0; k < 6; k++) begin
            s = k[1];
            en = (k < 4);
            wr_reg(OFF_OUT_CTRL, {12'h000, s, 3'h0});
            wr_reg(OFF_REQ_EN, en ? 16'h0300 : 16'h0000);
            c0 = n_ch1;
            u0 = n_upd;
            pulse(k[0] ? 3'h1 : 3'h2);
            cyc(3);
            chk(16'(n_ch1 - c0), 16'(en && (s == k[0])));
            chk(16'(n_upd - u0), 16'(en && k[0]));
        end
        wr_reg(OFF_STATUS, 16'hffff);
        wr_reg(OFF_OUT_CTRL, 16'h0000);
    endtask

    // masked flag keeps irq low; enabling it later raises irq
    task automatic t_irq();
        logic [2:0] m[3] = '{3'h1, 3'h2, 3'h4};
        logic [15:0] b[3] = '{16'h0001, 16'h0002, 16'h0080};
        for (int i = 0; i < 3; i++) begin
            wr_reg(OFF_REQ_EN, 16'h0000);
            pulse(m[i]);
            cyc(2);
            chk(16'(irq), 16'h0000);
            rd_chk(OFF_STATUS, b[i]);
            wr_reg(OFF_REQ_EN, b[i]);
            cyc(2);
            chk(16'(irq), 16'h0001);
            wr_reg(OFF_STATUS, b[i]);
            cyc(2);
            chk(16'(irq), 16'h0000);
        end
    endtask

    task automatic t_switch();
        wr_reg(OFF_REQ_EN, 16'h0020);
        wr_reg(OFF_CH_PEND, 16'h0015);
        cyc(1);
        rd_chk(OFF_CH_ACT, 16'h0015);
        chk(16'(mode), 16'h0001);
        wr_reg(OFF_OUT_CTRL, 16'h0001);
        wr_reg(OFF_CH_PEND, 16'h0034);
        trig_rise();
        cyc(2);
        rd_chk(OFF_CH_ACT, 16'h0015);
        chk(16'(irq), 16'h0000);
        wr_reg(OFF_SW_GEN, 16'h0020);
        cyc(2);
        rd_chk(OFF_CH_ACT, 16'h0034);
        chk(16'(irq), 16'h0001);
        rd_chk(OFF_STATUS, 16'h0020);
        wr_reg(OFF_STATUS, 16'h0020);
        wr_reg(OFF_OUT_CTRL, 16'h0005);
        wr_reg(OFF_CH_PEND, 16'h0045);
        trig_rise();
        cyc(2);
        rd_chk(OFF_CH_ACT, 16'h0045);
        chk(16'(mode), 16'h0004);
        rd_chk(OFF_STATUS, 16'h0020);
        wr_reg(OFF_REQ_EN, 16'h0000);
        cyc(2);
        chk(16'(irq), 16'h0000);
        wr_reg(OFF_STATUS, 16'h0020);
    endtask

    // both outputs enabled and running, then main enable drops
    task automatic t_idle();
        int i;
        logic [1:0] exp;
        for (int k = 1; k < 3; k++) begin
            exp = (k == 1) ? 2'b10 : 2'b01;
            wr_reg(OFF_OUT_CTRL, 16'(k) << 8);
            @(posedge clk_sys);
            main_en <= 1'b1;
            cyc(3);
            chk(16'({out_m, out_n}), 16'h0003);
            @(posedge clk_sys);
            main_en <= 1'b0;
            cyc(2);
            chk(16'({out_m, out_n}), 16'h0000);
            i = 0;
            while (i < 10 && {out_m, out_n} !== exp) begin
                cyc(1);
                i++;
            end
            chk(16'({out_m, out_n}), 16'(exp));
            // four dead cycles: idle level shows three polls after the first low check
            chk(16'(i), 16'h0003);
        end
    endtask

    // ------------------------------------------------------------
    // verdict and main sequence
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = '0;
        evt = 3'h0;
        trig = 1'b0;
        main_en = 1'b0;
        lock = 2'h0;
        run_m = 1'b1;
        run_n = 1'b1;
        failures = 0;
        n_checks = 0;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_regs();
        t_lock();
        t_dma();
        t_irq();
        t_switch();
        t_idle();
        report_and_stop();
    end

    // watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
